// *** pin_share_consts.svh ***
`ifndef PIN_SHARE_CONSTS_SVH
`define PIN_SHARE_CONSTS_SVH
// Contract
// - Standard pins 0,1,2,3,9 reset to general-purpose role, driving low.
// - Four fast pins reset to general-purpose role, output released.
// - Fast pin general-purpose drive exists only while dual-link operation is active; the SPI alternate is not gated.
// - Pins 5 to 8 are register controlled only, reset general-purpose low.
// - Each shared pin's role comes from a register setting, not a pin.
// - Surround mode drives word clock, bit clock and two data outputs.
`define STD_PIN_COUNT    5
`define FAST_PIN_COUNT   4
`define REG_PIN_COUNT    4
`define STD_OUT_RESET    5'h00
`define STD_OE_RESET     5'h1f
`define FAST_OE_RESET    4'h0
`define REG_OUT_RESET    4'h0
`define REG_OE_RESET     4'hf
`define STD_ALT_RESET    1'b0
`define FAST_ALT_RESET   1'b0
`define REG_ALT_RESET    1'b0
// Positions of the surround signals within the register-only pin group.
`define SS_DATA_B_BIT    0
`define SS_DATA_A_BIT    1
`define SS_WORD_CLK_BIT  2
`define SS_BIT_CLK_BIT   3
`endif

// *** pin_share_pkg.sv ***
package pin_share_pkg;
  // Role of a shared pin group.
  typedef enum logic [1:0] {
    ROLE_GPIO = 2'b01,
    ROLE_ALT  = 2'b10
  } pin_role_t;
endpackage : pin_share_pkg

// *** pin_cell.sv ***
`include "pin_share_consts.svh"
// One shared pin: a general-purpose output and an alternate function, with
// the role chosen by a registered select. Output and enable are registered.
module pin_cell #(
  parameter logic RST_OUT = 1'b0,
  parameter logic RST_OE  = 1'b0
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic alt_sel,
  input  wire logic gpio_out,
  input  wire logic gpio_oe,
  input  wire logic alt_out,
  input  wire logic alt_oe,
  output logic      pin_out_r,
  output logic      pin_oe_r
);
  // The selected source is latched each cycle so the pin is glitch free.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_out_r <= RST_OUT;
      pin_oe_r  <= RST_OE;
    end else begin
      pin_out_r <= alt_sel ? alt_out : gpio_out;
      pin_oe_r  <= alt_sel ? alt_oe : gpio_oe;
    end
  end
endmodule : pin_cell

// *** gpio_audio_pin_sharing.sv ***
`include "pin_share_consts.svh"
// Pin sharing for the standard, fast and register-only general-purpose pins.
// Configuration arrives as plain ports from the register block; a new value
// is taken only on its write strobe, so the roles hold between writes.
module gpio_audio_pin_sharing (
  input  wire logic                        ref_clk,
  input  wire logic                        resetn,
  // Register block write strobes and data.
  input  wire logic                        std_cfg_we,
  input  wire logic                        std_alt_wdata,
  input  wire logic [`STD_PIN_COUNT-1:0]   std_out_wdata,
  input  wire logic [`STD_PIN_COUNT-1:0]   std_oe_wdata,
  input  wire logic                        fast_cfg_we,
  input  wire logic                        fast_alt_wdata,
  input  wire logic [`FAST_PIN_COUNT-1:0]  fast_out_wdata,
  input  wire logic [`FAST_PIN_COUNT-1:0]  fast_oe_wdata,
  input  wire logic                        reg_cfg_we,
  input  wire logic                        reg_alt_wdata,
  input  wire logic [`REG_PIN_COUNT-1:0]   reg_out_wdata,
  input  wire logic [`REG_PIN_COUNT-1:0]   reg_oe_wdata,
  input  wire logic                        dual_link,
  // Alternate function sources.
  input  wire logic [`STD_PIN_COUNT-1:0]   aux_audio_out,
  input  wire logic                        spi_out_0,
  input  wire logic                        spi_out_1,
  input  wire logic                        spi_out_2,
  input  wire logic                        spi_out_3,
  input  wire logic [`FAST_PIN_COUNT-1:0]  spi_oe,
  input  wire logic                        surround_word_clock,
  input  wire logic                        surround_bit_clock,
  input  wire logic                        surround_data_a,
  input  wire logic                        surround_data_b,
  // Pin drivers; enable is high while the device drives the pin.
  output logic [`STD_PIN_COUNT-1:0]        std_pin_out,
  output logic [`STD_PIN_COUNT-1:0]        std_pin_oe,
  output logic [`FAST_PIN_COUNT-1:0]       fast_pin_out,
  output logic [`FAST_PIN_COUNT-1:0]       fast_pin_oe,
  output logic [`REG_PIN_COUNT-1:0]        reg_only_pin_out,
  output logic [`REG_PIN_COUNT-1:0]        reg_only_pin_oe,
  // Current role of each group, for status readback.
  output logic                             std_alt_r,
  output logic                             fast_alt_r,
  output logic                             reg_alt_r
);
  logic [`STD_PIN_COUNT-1:0]  std_out_r;
  logic [`STD_PIN_COUNT-1:0]  std_oe_r;
  logic [`FAST_PIN_COUNT-1:0] fast_out_r;
  logic [`FAST_PIN_COUNT-1:0] fast_oe_r;
  logic [`REG_PIN_COUNT-1:0]  reg_out_r;
  logic [`REG_PIN_COUNT-1:0]  reg_oe_r;
  logic [`FAST_PIN_COUNT-1:0] fast_gpio_oe;
  logic [`FAST_PIN_COUNT-1:0] fast_alt_out;
  logic [`REG_PIN_COUNT-1:0]  surround_bus;
  pin_share_pkg::pin_role_t   std_role;
  logic                       std_sel;

  // Standard pins start as general purpose driving low.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      std_alt_r <= `STD_ALT_RESET;
      std_out_r <= `STD_OUT_RESET;
      std_oe_r  <= `STD_OE_RESET;
    end else if (std_cfg_we) begin
      std_alt_r <= std_alt_wdata;
      std_out_r <= std_out_wdata;
      std_oe_r  <= std_oe_wdata;
    end
  end

  // Fast pins start released; their role changes only on a write.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fast_alt_r <= `FAST_ALT_RESET;
      fast_out_r <= '0;
      fast_oe_r  <= `FAST_OE_RESET;
    end else if (fast_cfg_we) begin
      fast_alt_r <= fast_alt_wdata;
      fast_out_r <= fast_out_wdata;
      fast_oe_r  <= fast_oe_wdata;
    end
  end

  // Register-only pins have no strap or pin control at all.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_alt_r <= `REG_ALT_RESET;
      reg_out_r <= `REG_OUT_RESET;
      reg_oe_r  <= `REG_OE_RESET;
    end else if (reg_cfg_we) begin
      reg_alt_r <= reg_alt_wdata;
      reg_out_r <= reg_out_wdata;
      reg_oe_r  <= reg_oe_wdata;
    end
  end

  // Fast GPIO drive is gated by dual link; in single link the GPIO role leaves the pins floating.
  // The host must clear the jitter cleaner before enabling surround mode;
  // this block drives the bit clock regardless and does not check it.
  always_comb begin
    fast_gpio_oe = dual_link ? fast_oe_r : '0;
    fast_alt_out = {spi_out_3, spi_out_2, spi_out_1, spi_out_0};
    surround_bus = '0;
    surround_bus[`SS_DATA_B_BIT]   = surround_data_b;
    surround_bus[`SS_DATA_A_BIT]   = surround_data_a;
    surround_bus[`SS_WORD_CLK_BIT] = surround_word_clock;
    surround_bus[`SS_BIT_CLK_BIT]  = surround_bit_clock;
    std_role = std_alt_r ? pin_share_pkg::ROLE_ALT : pin_share_pkg::ROLE_GPIO;
    std_sel  = (std_role == pin_share_pkg::ROLE_ALT);
  end

  // Standard pins: the alternate is the auxiliary audio output set, which
  // only ever drives. Slot 4 of each bus is pin 9; slots 0 to 3 are pins 0-3.
  pin_cell #(.RST_OUT(1'b0), .RST_OE(1'b1)) u_std_0 (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .alt_sel   (std_sel),
    .gpio_out  (std_out_r[0]),
    .gpio_oe   (std_oe_r[0]),
    .alt_out   (aux_audio_out[0]),
    .alt_oe    (1'b1),
    .pin_out_r (std_pin_out[0]),
    .pin_oe_r  (std_pin_oe[0])
  );

  pin_cell #(.RST_OUT(1'b0), .RST_OE(1'b1)) u_std_1 (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .alt_sel   (std_sel),
    .gpio_out  (std_out_r[1]),
    .gpio_oe   (std_oe_r[1]),
    .alt_out   (aux_audio_out[1]),
    .alt_oe    (1'b1),
    .pin_out_r (std_pin_out[1]),
    .pin_oe_r  (std_pin_oe[1])
  );

  pin_cell #(.RST_OUT(1'b0), .RST_OE(1'b1)) u_std_2 (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .alt_sel   (std_sel),
    .gpio_out  (std_out_r[2]),
    .gpio_oe   (std_oe_r[2]),
    .alt_out   (aux_audio_out[2]),
    .alt_oe    (1'b1),
    .pin_out_r (std_pin_out[2]),
    .pin_oe_r  (std_pin_oe[2])
  );

  pin_cell #(.RST_OUT(1'b0), .RST_OE(1'b1)) u_std_3 (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .alt_sel   (std_sel),
    .gpio_out  (std_out_r[3]),
    .gpio_oe   (std_oe_r[3]),
    .alt_out   (aux_audio_out[3]),
    .alt_oe    (1'b1),
    .pin_out_r (std_pin_out[3]),
    .pin_oe_r  (std_pin_oe[3])
  );

  // Pin 9 shares the group select, so it cannot be switched on its own.
  pin_cell #(.RST_OUT(1'b0), .RST_OE(1'b1)) u_std_4 (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .alt_sel   (std_sel),
    .gpio_out  (std_out_r[4]),
    .gpio_oe   (std_oe_r[4]),
    .alt_out   (aux_audio_out[4]),
    .alt_oe    (1'b1),
    .pin_out_r (std_pin_out[4]),
    .pin_oe_r  (std_pin_oe[4])
  );

  // Fast pins: the alternate is the SPI signal set. Only the GPIO enable is
  // gated by dual link; the SPI enables pass through as given.
  pin_cell #(.RST_OUT(1'b0), .RST_OE(1'b0)) u_fast_0 (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .alt_sel   (fast_alt_r),
    .gpio_out  (fast_out_r[0]),
    .gpio_oe   (fast_gpio_oe[0]),
    .alt_out   (fast_alt_out[0]),
    .alt_oe    (spi_oe[0]),
    .pin_out_r (fast_pin_out[0]),
    .pin_oe_r  (fast_pin_oe[0])
  );

  pin_cell #(.RST_OUT(1'b0), .RST_OE(1'b0)) u_fast_1 (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .alt_sel   (fast_alt_r),
    .gpio_out  (fast_out_r[1]),
    .gpio_oe   (fast_gpio_oe[1]),
    .alt_out   (fast_alt_out[1]),
    .alt_oe    (spi_oe[1]),
    .pin_out_r (fast_pin_out[1]),
    .pin_oe_r  (fast_pin_oe[1])
  );

  pin_cell #(.RST_OUT(1'b0), .RST_OE(1'b0)) u_fast_2 (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .alt_sel   (fast_alt_r),
    .gpio_out  (fast_out_r[2]),
    .gpio_oe   (fast_gpio_oe[2]),
    .alt_out   (fast_alt_out[2]),
    .alt_oe    (spi_oe[2]),
    .pin_out_r (fast_pin_out[2]),
    .pin_oe_r  (fast_pin_oe[2])
  );

  pin_cell #(.RST_OUT(1'b0), .RST_OE(1'b0)) u_fast_3 (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .alt_sel   (fast_alt_r),
    .gpio_out  (fast_out_r[3]),
    .gpio_oe   (fast_gpio_oe[3]),
    .alt_out   (fast_alt_out[3]),
    .alt_oe    (spi_oe[3]),
    .pin_out_r (fast_pin_out[3]),
    .pin_oe_r  (fast_pin_oe[3])
  );

  // Register-only pins: the alternate is surround audio, always driven.
  // Slot 0 is pin 5 (data B), 1 is pin 6 (data A), 2 is pin 7 (word clock)
  // and 3 is pin 8 (bit clock).
  pin_cell #(.RST_OUT(1'b0), .RST_OE(1'b1)) u_reg_0 (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .alt_sel   (reg_alt_r),
    .gpio_out  (reg_out_r[0]),
    .gpio_oe   (reg_oe_r[0]),
    .alt_out   (surround_bus[0]),
    .alt_oe    (1'b1),
    .pin_out_r (reg_only_pin_out[0]),
    .pin_oe_r  (reg_only_pin_oe[0])
  );

  pin_cell #(.RST_OUT(1'b0), .RST_OE(1'b1)) u_reg_1 (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .alt_sel   (reg_alt_r),
    .gpio_out  (reg_out_r[1]),
    .gpio_oe   (reg_oe_r[1]),
    .alt_out   (surround_bus[1]),
    .alt_oe    (1'b1),
    .pin_out_r (reg_only_pin_out[1]),
    .pin_oe_r  (reg_only_pin_oe[1])
  );

  pin_cell #(.RST_OUT(1'b0), .RST_OE(1'b1)) u_reg_2 (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .alt_sel   (reg_alt_r),
    .gpio_out  (reg_out_r[2]),
    .gpio_oe   (reg_oe_r[2]),
    .alt_out   (surround_bus[2]),
    .alt_oe    (1'b1),
    .pin_out_r (reg_only_pin_out[2]),
    .pin_oe_r  (reg_only_pin_oe[2])
  );

  // The bit clock is registered like the rest, so its edges lag the source
  // by one core cycle; it must run well below half the core clock.
  pin_cell #(.RST_OUT(1'b0), .RST_OE(1'b1)) u_reg_3 (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .alt_sel   (reg_alt_r),
    .gpio_out  (reg_out_r[3]),
    .gpio_oe   (reg_oe_r[3]),
    .alt_out   (surround_bus[3]),
    .alt_oe    (1'b1),
    .pin_out_r (reg_only_pin_out[3]),
    .pin_oe_r  (reg_only_pin_oe[3])
  );
endmodule : gpio_audio_pin_sharing

// *** pin_share_assertions.sv ***
module pin_share_assertions (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       std_cfg_we,
  input wire logic       std_alt_wdata,
  input wire logic [4:0] std_out_wdata,
  input wire logic       fast_cfg_we,
  input wire logic       fast_alt_wdata,
  input wire logic [3:0] fast_oe_wdata,
  input wire logic       reg_cfg_we,
  input wire logic       reg_alt_wdata,
  input wire logic [3:0] reg_out_wdata,
  input wire logic       dual_link,
  input wire logic       surround_word_clock,
  input wire logic       surround_bit_clock,
  input wire logic       surround_data_a,
  input wire logic       surround_data_b,
  input wire logic [4:0] std_pin_out,
  input wire logic [4:0] std_pin_oe,
  input wire logic [3:0] fast_pin_oe,
  input wire logic [3:0] reg_only_pin_out,
  input wire logic [3:0] reg_only_pin_oe,
  input wire logic       fast_alt_r,
  input wire logic       reg_alt_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Pins come out of reset in their general-purpose defaults.
  reset_dflt_a: assert property (
    $rose(resetn) |-> std_pin_out == 5'h00 && std_pin_oe == 5'h1f
    && fast_pin_oe == 4'h0 && reg_only_pin_oe == 4'hf
    && reg_only_pin_out == 4'h0) else $error("reset pin state wrong");
  fast_gate_a: assert property (
    !dual_link && !fast_alt_r |=> fast_pin_oe == 4'h0)
    else $error("fast pin driven in single link");
  role_hold_a: assert property (!reg_cfg_we |=> $stable(reg_alt_r))
    else $error("role changed without write");
  role_load_a: assert property (
    reg_cfg_we |=> reg_alt_r == $past(reg_alt_wdata))
    else $error("role not loaded");
  // The surround bus reaches the pins one cycle after its sources.
  ss_drive_a: assert property (reg_alt_r |=> reg_only_pin_oe == 4'hf
    && reg_only_pin_out == $past({surround_bit_clock, surround_word_clock,
    surround_data_a, surround_data_b})) else $error("surround drive wrong");
  std_gpio_a: assert property (
    std_cfg_we && !std_alt_wdata ##2 1 |-> std_pin_out
    == $past(std_out_wdata, 2)) else $error("std pin value wrong");
  fast_gpio_a: assert property (
    fast_cfg_we && !fast_alt_wdata ##1 dual_link |=> fast_pin_oe
    == $past(fast_oe_wdata, 2)) else $error("fast pin enable wrong");
  reg_gpio_a: assert property (
    reg_cfg_we && !reg_alt_wdata ##2 1 |-> reg_only_pin_out
    == $past(reg_out_wdata, 2)) else $error("reg pin value wrong");
  cover property (reg_alt_r);
  cover property (fast_alt_r && !dual_link);
  cover property (std_cfg_we && std_alt_wdata);
endmodule : pin_share_assertions

// *** host_cfg_model.sv ***
module host_cfg_model (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic sel_we,
  input  wire logic surround_sel,
  output logic      jitter_off_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // The host writes the jitter-cleaner disable bit together with each register-only group role
  // write, so the cleaner is already off when the surround bit clock starts.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) jitter_off_r <= 1'b0;
    else if (sel_we) jitter_off_r <= surround_sel;
  end
endmodule : host_cfg_model

// *** gpio_audio_pin_sharing_tb_top.sv ***
module gpio_audio_pin_sharing_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, resetn = 0, jitter_off;
  logic std_cfg_we = 0, std_alt_wdata = 0, fast_cfg_we = 0, dual_link = 0;
  logic fast_alt_wdata = 0, reg_cfg_we = 0, reg_alt_wdata = 0;
  logic spi_out_0 = 0, spi_out_1 = 0, spi_out_2 = 0, spi_out_3 = 0;
  logic surround_word_clock = 0, surround_bit_clock = 0;
  logic surround_data_a = 0, surround_data_b = 0;
  logic [4:0] std_out_wdata = 0, std_oe_wdata = 0, aux_audio_out = 0;
  logic [3:0] fast_out_wdata = 0, fast_oe_wdata = 0, spi_oe = 0;
  logic [3:0] reg_out_wdata = 0, reg_oe_wdata = 0;
  logic [4:0] std_pin_out, std_pin_oe, exp_v [7];
  logic [3:0] fast_pin_out, fast_pin_oe, reg_only_pin_out, reg_only_pin_oe;
  logic std_alt_r, fast_alt_r, reg_alt_r;
  wire [3:0] spi = {spi_out_3, spi_out_2, spi_out_1, spi_out_0};
  wire [3:0] ss = {surround_bit_clock, surround_word_clock,
                   surround_data_a, surround_data_b};
  int fails = 0, compares = 0;
  gpio_audio_pin_sharing uut (.*);
  host_cfg_model hm (.ref_clk(ref_clk), .resetn(resetn), .sel_we(reg_cfg_we),
                     .surround_sel(reg_alt_wdata), .jitter_off_r(jitter_off));
  always #2 ref_clk = ~ref_clk;
  task automatic chk(input string nm, input logic [4:0] e, g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Expected pins come from the data written and the live alternates.
  task automatic predict();
    exp_v[0] = std_alt_wdata ? aux_audio_out : std_out_wdata;
    exp_v[1] = std_alt_wdata ? 5'h1f : std_oe_wdata;
    exp_v[2] = {1'b0, fast_alt_wdata ? spi : fast_out_wdata};
    exp_v[3] = {1'b0, fast_alt_wdata ? spi_oe
                                     : fast_oe_wdata & {4{dual_link}}};
    exp_v[4] = {1'b0, reg_alt_wdata ? ss : reg_out_wdata};
    exp_v[5] = {1'b0, reg_alt_wdata ? 4'hf : reg_oe_wdata};
    exp_v[6] = {2'b00, std_alt_wdata, fast_alt_wdata, reg_alt_wdata};
  endtask : predict
  task automatic chk_pins();
    chk("std_pin_out", exp_v[0], std_pin_out);
    chk("std_pin_oe", exp_v[1], std_pin_oe);
    chk("fast_pin_out", exp_v[2], {1'b0, fast_pin_out});
    chk("fast_pin_oe", exp_v[3], {1'b0, fast_pin_oe});
    chk("reg_only_pin_out", exp_v[4], {1'b0, reg_only_pin_out});
    chk("reg_only_pin_oe", exp_v[5], {1'b0, reg_only_pin_oe});
    chk("roles", exp_v[6], {2'b00, std_alt_r, fast_alt_r, reg_alt_r});
    if (exp_v[6][0]) chk("jitter_off", 5'h01, {4'h0, jitter_off});
  endtask : chk_pins
  // Write all groups, then flip the roles without a strobe.
  task automatic trial(input bit corner);
    logic [3:0]  roles;
    logic [15:0] fast_reg;
    roles    = 4'($urandom);
    fast_reg = 16'($urandom);
    // Corner: single link with every fast GPIO enable asked for.
    if (corner) begin
      roles[2]       = 1'b0;
      roles[0]       = 1'b0;
      fast_reg[11:8] = 4'hf;
    end
    @(posedge ref_clk);
    {std_cfg_we, fast_cfg_we, reg_cfg_we} <= 3'h7;
    {std_alt_wdata, fast_alt_wdata, reg_alt_wdata, dual_link} <= roles;
    {std_out_wdata, std_oe_wdata, aux_audio_out} <= 15'($urandom);
    {fast_out_wdata, fast_oe_wdata, reg_out_wdata, reg_oe_wdata} <= fast_reg;
    {spi_oe, spi_out_3, spi_out_2, spi_out_1, spi_out_0} <= 8'($urandom);
    {surround_bit_clock, surround_word_clock, surround_data_a,
     surround_data_b} <= 4'($urandom);
    @(posedge ref_clk);
    {std_cfg_we, fast_cfg_we, reg_cfg_we} <= 3'h0;
    #1 predict();
    @(posedge ref_clk);
    #1 chk_pins();
    @(posedge ref_clk);
    {std_alt_wdata, fast_alt_wdata, reg_alt_wdata} <= 3'($urandom);
    repeat (2) @(posedge ref_clk);
    #1 chk_pins();
  endtask : trial
  task automatic do_reset();
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (8) @(posedge ref_clk);
    #1 chk("std_pin_oe", 5'h1f, std_pin_oe);
    chk("std_pin_out", 5'h00, std_pin_out);
    chk("fast_pin_oe", 5'h00, {1'b0, fast_pin_oe});
    chk("reg_only_pin_out", 5'h00, {1'b0, reg_only_pin_out});
    chk("reg_only_pin_oe", 5'h0f, {1'b0, reg_only_pin_oe});
    chk("roles", 5'h00, {2'b00, std_alt_r, fast_alt_r, reg_alt_r});
    @(posedge ref_clk);
    resetn <= 1'b1;
  endtask : do_reset
  task automatic give_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // Ends a hung run well past the expected length of all trials.
  initial begin
    #20000;
    fails++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h4800));
    do_reset();
    for (int i = 0; i < 120; i++) trial(i < 4);
    do_reset();
    for (int i = 0; i < 20; i++) trial(1'b0);
    give_verdict();
  end
endmodule : gpio_audio_pin_sharing_tb_top
bind gpio_audio_pin_sharing pin_share_assertions chk_i (.*);
